// file: shared/esc_pkg.sv
// ---------------------------------------------------------------
// Structure builder constants
// ---------------------------------------------------------------
package esc_pkg;
  // Register offsets of the software port
  localparam logic [7:0] REG_CTRL = 8'h00; // Start pulse and kind
  localparam logic [7:0] REG_BASE = 8'h04; // Target byte address
  localparam logic [7:0] REG_STATUS = 8'h08; // Busy, done, errors
  localparam logic [7:0] REG_FEAT = 8'h0C; // Save-frame feature enumeration
  localparam logic [7:0] REG_STG_ADDR = 8'h10; // Staging word index
  localparam logic [7:0] REG_STG_DATA = 8'h14; // Staging data, auto-increments
  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ALIGN = 2;
  localparam int ST_DATE = 3;
  localparam int ST_MISC = 4;
  localparam int ST_FAIL = 5;
  // Reset values
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [31:0] FEAT_RST = 32'h0000_0000;
  localparam logic [1:0] KIND_RST = 2'h0;
  // Structure kinds
  localparam logic [1:0] KIND_SIG = 2'h0; // Enclave signature record
  localparam logic [1:0] KIND_TOKEN = 2'h1; // Launch permit token
  localparam logic [1:0] KIND_PAGING = 2'h2; // Paging crypto record
  // Last word index of each kind (bytes / 4 - 1)
  localparam logic [8:0] SIG_LAST = 9'h1C3; // 1808 bytes
  localparam logic [8:0] TOKEN_LAST = 9'h04B; // 304 bytes
  localparam logic [8:0] PAGING_LAST = 9'h01F; // 128 bytes
  // Alignment masks of the base address
  localparam logic [31:0] SIG_ALIGN = 32'h0000_0FFF; // Page
  localparam logic [31:0] TOKEN_ALIGN = 32'h0000_01FF; // 512 bytes
  // Signature record word indices
  localparam logic [8:0] SIG_HDR_LO = 9'h000; // Header 0..15
  localparam logic [8:0] SIG_HDR_HI = 9'h003;
  localparam logic [8:0] SIG_DATE_W = 9'h005; // Date at 20
  localparam logic [8:0] SIG_HDR2_LO = 9'h006; // Second header 24..39
  localparam logic [8:0] SIG_HDR2_HI = 9'h009;
  localparam logic [8:0] SIG_RSV0_LO = 9'h00B; // Reserved 44..127
  localparam logic [8:0] SIG_RSV0_HI = 9'h01F;
  localparam logic [8:0] SIG_EXP_W = 9'h080; // Exponent at 512
  localparam logic [8:0] SIG_SEL_W = 9'h0E1; // Save-feature select at 900
  localparam logic [8:0] SIG_MASK_W = 9'h0E2; // Enforce mask at 904
  localparam logic [8:0] SIG_RSV1_LO = 9'h0E3; // Reserved 908..927
  localparam logic [8:0] SIG_RSV1_HI = 9'h0E7;
  localparam logic [8:0] SIG_RSV2_LO = 9'h0F8; // Reserved 992..1023
  localparam logic [8:0] SIG_RSV2_HI = 9'h0FF;
  localparam logic [8:0] SIG_RSV3_LO = 9'h101; // Reserved 1028..1039
  localparam logic [8:0] SIG_RSV3_HI = 9'h103;
  localparam logic [31:0] SIG_EXPONENT = 32'h0000_0003;
  // Header streams, byte 0 in the low lane of word 0
  localparam logic [127:0] SIG_HDR = 128'h0000_0000_0001_0000_0000_00E1_0000_0006;
  localparam logic [127:0] SIG_HDR2 = 128'h0000_0001_0000_0060_0000_0060_0000_0101;
  // Launch permit token word indices
  localparam logic [8:0] TOK_FLAG_W = 9'h000; // Valid/debug word
  localparam logic [31:0] TOK_FLAG_MASK = 32'h0000_0001;
  localparam logic [8:0] TOK_RSV0_LO = 9'h001; // Reserved 4..47
  localparam logic [8:0] TOK_RSV0_HI = 9'h00B;
  localparam logic [8:0] TOK_RSV1_LO = 9'h018; // Reserved 96..127
  localparam logic [8:0] TOK_RSV1_HI = 9'h01F;
  localparam logic [8:0] TOK_RSV2_LO = 9'h028; // Reserved 160..191
  localparam logic [8:0] TOK_RSV2_HI = 9'h02F;
  localparam logic [8:0] TOK_RSV3_LO = 9'h035; // Reserved 212..235
  localparam logic [8:0] TOK_RSV3_HI = 9'h03A;
  // Paging crypto record reserved area 72..111
  localparam logic [8:0] PCR_RSV_LO = 9'h012;
  localparam logic [8:0] PCR_RSV_HI = 9'h01B;
endpackage

// file: rtl/esc_stage_ram.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Staging memory, one write port and one registered read port
// ---------------------------------------------------------------
module esc_stage_ram (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [8:0] waddr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [8:0] raddr_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:511]; // Big enough for the longest record

  // Write side, filled by software
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read side, data one cycle after the address
  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end
endmodule // esc_stage_ram

// file: rtl/esc_host_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Paging reserved 72..111 zero, MAC at 112
// - Digests keep dword most-significant-byte-left order
// - Big integers stored little-endian, 384 bytes
// - Signature uses exponent 3, 3072-bit modulus
// - Signer supplies both helper quotients
// - Signature record base is page aligned
// - Date is BCD yyyymmdd with valid ranges
// - Signed region fields kept, reserved zeroed
// - Masked-off select bits must be zero; checked only when the feature enumeration is nonzero
// - Token base is 512-byte aligned
module esc_host_ctrl (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic [31:0] MEM_ADDR_OUT,
  output logic [31:0] MEM_WDATA_OUT,
  output logic MEM_WE_OUT,
  output logic OP_REQ_OUT,
  output logic [1:0] OP_KIND_OUT,
  input wire logic OP_DONE_IN,
  input wire logic OP_FAIL_IN
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_DATE0, S_DATE1, S_SEL0, S_SEL1, S_MASK0, S_MASK1,
                S_EMIT, S_DRAIN, S_REQ, S_WAIT} esc_state_t;
  esc_state_t state; // Sequencer state
  logic [1:0] kind; // Structure kind being handed over
  logic [31:0] base; // Byte address of the structure
  logic [31:0] feat; // Save-frame feature enumeration copy
  logic [8:0] stg_addr; // Software staging pointer
  logic [8:0] rd_idx; // Staging read pointer
  logic [8:0] emit_idx; // Index of the word now on the read port
  logic emit_v; // Read port holds a word to emit
  logic [8:0] out_idx; // Index of the word on the memory pins
  logic [31:0] sel_word; // Captured save-feature select
  logic [31:0] stg_rdata; // Staging read data
  logic [5:0] status; // Busy, done and error flags
  logic [8:0] last_idx; // Final word of the current kind
  logic start; // Software start request
  logic align_bad; // Base violates the kind's alignment
  logic [2:0] done_sync; // Done synchroniser and edge stage
  logic [2:0] fail_sync; // Fail synchroniser and edge stage

  assign start = REG_WR_IN && REG_ADDR_IN == esc_pkg::REG_CTRL && REG_WDATA_IN[esc_pkg::CTRL_START_BIT];
  assign last_idx = (kind == esc_pkg::KIND_SIG) ? esc_pkg::SIG_LAST :
                    (kind == esc_pkg::KIND_TOKEN) ? esc_pkg::TOKEN_LAST : esc_pkg::PAGING_LAST;
  // Alignment of the requested kind, taken from the write data
  always_comb begin
    case (REG_WDATA_IN[esc_pkg::CTRL_KIND_LSB +: 2])
      esc_pkg::KIND_SIG: align_bad = (base & esc_pkg::SIG_ALIGN) != 32'h0000_0000;
      esc_pkg::KIND_TOKEN: align_bad = (base & esc_pkg::TOKEN_ALIGN) != 32'h0000_0000;
      default: align_bad = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Word fix-up: constant, zeroed, masked or passed straight through
  // ---------------------------------------------------------------
  function automatic logic in_rng(input logic [8:0] i, input logic [8:0] lo, input logic [8:0] hi);
    in_rng = i >= lo && i <= hi;
  endfunction

  function automatic logic [31:0] fix_word(input logic [1:0] k, input logic [8:0] i, input logic [31:0] raw);
    fix_word = raw; // Digests, integers and both quotients keep their staged byte order
    case (k)
      esc_pkg::KIND_SIG: begin
        if (in_rng(i, esc_pkg::SIG_HDR_LO, esc_pkg::SIG_HDR_HI)) begin
          fix_word = esc_pkg::SIG_HDR[i[1:0]*32 +: 32];
        end else if (in_rng(i, esc_pkg::SIG_HDR2_LO, esc_pkg::SIG_HDR2_HI)) begin
          fix_word = esc_pkg::SIG_HDR2[2'(i - esc_pkg::SIG_HDR2_LO)*32 +: 32];
        end else if (i == esc_pkg::SIG_EXP_W) begin
          fix_word = esc_pkg::SIG_EXPONENT;
        end else if (in_rng(i, esc_pkg::SIG_RSV0_LO, esc_pkg::SIG_RSV0_HI)
                     || in_rng(i, esc_pkg::SIG_RSV1_LO, esc_pkg::SIG_RSV1_HI)
                     || in_rng(i, esc_pkg::SIG_RSV2_LO, esc_pkg::SIG_RSV2_HI)
                     || in_rng(i, esc_pkg::SIG_RSV3_LO, esc_pkg::SIG_RSV3_HI)) begin
          fix_word = 32'h0000_0000;
        end
      end
      esc_pkg::KIND_TOKEN: begin
        if (i == esc_pkg::TOK_FLAG_W) begin
          fix_word = raw & esc_pkg::TOK_FLAG_MASK; // Reserved flag bits cleared
        end else if (in_rng(i, esc_pkg::TOK_RSV0_LO, esc_pkg::TOK_RSV0_HI)
                     || in_rng(i, esc_pkg::TOK_RSV1_LO, esc_pkg::TOK_RSV1_HI)
                     || in_rng(i, esc_pkg::TOK_RSV2_LO, esc_pkg::TOK_RSV2_HI)
                     || in_rng(i, esc_pkg::TOK_RSV3_LO, esc_pkg::TOK_RSV3_HI)) begin
          fix_word = 32'h0000_0000;
        end
      end
      esc_pkg::KIND_PAGING: begin
        if (in_rng(i, esc_pkg::PCR_RSV_LO, esc_pkg::PCR_RSV_HI)) begin
          fix_word = 32'h0000_0000;
        end
      end
      default: fix_word = raw;
    endcase
  endfunction

  // Date word holds BCD digits, month 1..12, day 1..31
  function automatic logic date_ok(input logic [31:0] d);
    date_ok = 1'b1;
    for (int n = 0; n < 8; n++) begin
      if (d[n*4 +: 4] > 4'h9) begin
        date_ok = 1'b0;
      end
    end
    if (d[15:8] < 8'h01 || d[15:8] > 8'h12 || d[7:0] < 8'h01 || d[7:0] > 8'h31) begin
      date_ok = 1'b0;
    end
  endfunction

  // ---------------------------------------------------------------
  // Staging memory
  // ---------------------------------------------------------------
  esc_stage_ram u_stage (
    .clk_in(CLK_SYS_IN),
    .we_in(REG_WR_IN && REG_ADDR_IN == esc_pkg::REG_STG_DATA && !status[esc_pkg::ST_BUSY]),
    .waddr_in(stg_addr),
    .wdata_in(REG_WDATA_IN),
    .raddr_in(rd_idx),
    .rdata_out(stg_rdata)
  );

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Configuration; refused while a hand-over is running
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      base <= esc_pkg::BASE_RST;
      feat <= esc_pkg::FEAT_RST;
      stg_addr <= 9'h000;
    end else if (REG_WR_IN && !status[esc_pkg::ST_BUSY]) begin
      case (REG_ADDR_IN)
        esc_pkg::REG_BASE: base <= REG_WDATA_IN;
        esc_pkg::REG_FEAT: feat <= REG_WDATA_IN;
        esc_pkg::REG_STG_ADDR: stg_addr <= REG_WDATA_IN[8:0];
        esc_pkg::REG_STG_DATA: stg_addr <= stg_addr + 9'h001;
        default: ;
      endcase
    end
  end

  // Read data for exactly one cycle after the strobe
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        esc_pkg::REG_CTRL: REG_RDATA_OUT <= {29'h0000_0000, kind, 1'b0};
        esc_pkg::REG_BASE: REG_RDATA_OUT <= base;
        esc_pkg::REG_STATUS: REG_RDATA_OUT <= {26'h000_0000, status};
        esc_pkg::REG_FEAT: REG_RDATA_OUT <= feat;
        esc_pkg::REG_STG_ADDR: REG_RDATA_OUT <= {23'h00_0000, stg_addr};
        default: REG_RDATA_OUT <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end else begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Device answer synchronisers
  // ---------------------------------------------------------------
  // Pins come from the device side; third stage only feeds edge detect
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      done_sync <= 3'h0;
      fail_sync <= 3'h0;
    end else begin
      done_sync <= {done_sync[1:0], OP_DONE_IN};
      fail_sync <= {fail_sync[1:0], OP_FAIL_IN};
    end
  end

  // ---------------------------------------------------------------
  // Sequencer: checks, emit, request, wait
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= S_IDLE;
      kind <= esc_pkg::KIND_RST;
      status <= 6'h00;
      rd_idx <= 9'h000;
      sel_word <= 32'h0000_0000;
      OP_REQ_OUT <= 1'b0;
      OP_KIND_OUT <= esc_pkg::KIND_RST;
    end else begin
      OP_REQ_OUT <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            kind <= REG_WDATA_IN[esc_pkg::CTRL_KIND_LSB +: 2];
            status <= 6'h00;
            if (align_bad) begin
              status[esc_pkg::ST_ALIGN] <= 1'b1; // Refused before any write
              status[esc_pkg::ST_DONE] <= 1'b1;
            end else if (REG_WDATA_IN[esc_pkg::CTRL_KIND_LSB +: 2] == esc_pkg::KIND_SIG) begin
              status[esc_pkg::ST_BUSY] <= 1'b1;
              rd_idx <= esc_pkg::SIG_DATE_W;
              state <= S_DATE0;
            end else begin
              status[esc_pkg::ST_BUSY] <= 1'b1;
              rd_idx <= 9'h000;
              state <= S_EMIT;
            end
          end
        end
        S_DATE0: state <= S_DATE1; // Memory latches the address
        S_DATE1: begin
          if (!date_ok(stg_rdata)) begin
            status[esc_pkg::ST_DATE] <= 1'b1;
            status[esc_pkg::ST_BUSY] <= 1'b0;
            status[esc_pkg::ST_DONE] <= 1'b1;
            state <= S_IDLE;
          end else begin
            rd_idx <= esc_pkg::SIG_SEL_W;
            state <= S_SEL0;
          end
        end
        S_SEL0: state <= S_SEL1;
        S_SEL1: begin
          sel_word <= stg_rdata;
          rd_idx <= esc_pkg::SIG_MASK_W;
          state <= S_MASK0;
        end
        S_MASK0: state <= S_MASK1;
        S_MASK1: begin
          // Only enforced when the feature enumeration is nonzero
          if (feat != 32'h0000_0000 && (sel_word & ~stg_rdata) != 32'h0000_0000) begin
            status[esc_pkg::ST_MISC] <= 1'b1;
            status[esc_pkg::ST_BUSY] <= 1'b0;
            status[esc_pkg::ST_DONE] <= 1'b1;
            state <= S_IDLE;
          end else begin
            rd_idx <= 9'h000;
            state <= S_EMIT;
          end
        end
        S_EMIT: begin
          rd_idx <= rd_idx + 9'h001;
          if (rd_idx == last_idx) begin
            state <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (!emit_v) begin
            state <= S_REQ;
          end
        end
        S_REQ: begin
          OP_REQ_OUT <= 1'b1; // Structure complete in memory first
          OP_KIND_OUT <= kind;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (done_sync[1] && !done_sync[2]) begin
            status[esc_pkg::ST_BUSY] <= 1'b0;
            status[esc_pkg::ST_DONE] <= 1'b1;
            state <= S_IDLE;
          end else if (fail_sync[1] && !fail_sync[2]) begin
            status[esc_pkg::ST_BUSY] <= 1'b0;
            status[esc_pkg::ST_DONE] <= 1'b1;
            status[esc_pkg::ST_FAIL] <= 1'b1; // Device rejected the structure
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Emit pipeline to the device memory
  // ---------------------------------------------------------------
  // Read address taken one edge, data one edge later, pins the next
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      emit_v <= 1'b0;
      emit_idx <= 9'h000;
      out_idx <= 9'h000;
      MEM_WE_OUT <= 1'b0;
      MEM_ADDR_OUT <= 32'h0000_0000;
      MEM_WDATA_OUT <= 32'h0000_0000;
    end else begin
      emit_v <= state == S_EMIT;
      emit_idx <= rd_idx;
      MEM_WE_OUT <= emit_v;
      if (emit_v) begin
        out_idx <= emit_idx;
        MEM_ADDR_OUT <= base + {21'h00_0000, emit_idx, 2'b00};
        MEM_WDATA_OUT <= fix_word(kind, emit_idx, stg_rdata);
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_exponent;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      MEM_WE_OUT && kind == esc_pkg::KIND_SIG && out_idx == esc_pkg::SIG_EXP_W |-> MEM_WDATA_OUT == 32'h0000_0003;
  endproperty
  a_exponent: assert property (p_exponent) else $error("exponent word not 3");

  property p_header;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      MEM_WE_OUT && kind == esc_pkg::KIND_SIG && out_idx == 9'h001 |-> MEM_WDATA_OUT == 32'h0000_00E1;
  endproperty
  a_header: assert property (p_header) else $error("header word 1 wrong");

  property p_pcr_rsv;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      MEM_WE_OUT && kind == esc_pkg::KIND_PAGING && out_idx >= 9'h012 && out_idx <= 9'h01B
      |-> MEM_WDATA_OUT == 32'h0000_0000;
  endproperty
  a_pcr_rsv: assert property (p_pcr_rsv) else $error("paging reserved not zero");

  property p_sig_rsv;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      MEM_WE_OUT && kind == esc_pkg::KIND_SIG && out_idx >= 9'h101 && out_idx <= 9'h103
      |-> MEM_WDATA_OUT == 32'h0000_0000;
  endproperty
  a_sig_rsv: assert property (p_sig_rsv) else $error("signature reserved not zero");

  property p_modulus_pass;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      emit_v && kind == esc_pkg::KIND_SIG && emit_idx >= 9'h020 && emit_idx < 9'h080
      |=> MEM_WE_OUT && MEM_WDATA_OUT == $past(stg_rdata);
  endproperty
  a_modulus_pass: assert property (p_modulus_pass) else $error("modulus bytes reordered");

  property p_digest_pass;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      emit_v && kind == esc_pkg::KIND_SIG && emit_idx >= 9'h0F0 && emit_idx <= 9'h0F7
      |=> MEM_WDATA_OUT == $past(stg_rdata);
  endproperty
  a_digest_pass: assert property (p_digest_pass) else $error("digest bytes reordered");

  property p_sig_align;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      OP_REQ_OUT && OP_KIND_OUT == esc_pkg::KIND_SIG |-> base[11:0] == 12'h000;
  endproperty
  a_sig_align: assert property (p_sig_align) else $error("signature record not page aligned");

  property p_tok_align;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      OP_REQ_OUT && OP_KIND_OUT == esc_pkg::KIND_TOKEN |-> base[8:0] == 9'h000;
  endproperty
  a_tok_align: assert property (p_tok_align) else $error("token not 512-byte aligned");

  property p_date;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state == S_DATE1 && stg_rdata[15:8] == 8'h13 |=> state == S_IDLE && status[esc_pkg::ST_DATE] ##1 !OP_REQ_OUT;
  endproperty
  a_date: assert property (p_date) else $error("bad month accepted");

  property p_misc;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state == S_MASK1 && feat != 32'h0000_0000 && (sel_word & ~stg_rdata) != 32'h0000_0000
      |=> status[esc_pkg::ST_MISC] && !status[esc_pkg::ST_BUSY];
  endproperty
  a_misc: assert property (p_misc) else $error("select outside mask accepted");
endmodule // esc_host_ctrl

// file: bench/esc_dev_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Device model: keeps emitted words, answers each hand-over
// ---------------------------------------------------------------
module esc_dev_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic we_in,
  input wire logic req_in,
  input wire logic fail_en_in,
  input wire logic slow_in,
  output logic done_out,
  output logic fail_out
);
  logic [31:0] mem [0:1023]; // Word image, byte k in lane k%4
  int nwr; // Words received so far
  int wait_cnt; // Cycles before answering, -1 when idle
  int hold; // Length left of the answer pulse
  // Words are kept for a later reload, which would check the MAC over them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nwr <= 0;
      wait_cnt <= -1;
      hold <= 0;
      done_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      if (we_in) begin
        mem[addr_in[11:2]] <= wdata_in;
        nwr <= nwr + 1;
      end
      // Slow mode tests that the host waits instead of timing out
      if (req_in) wait_cnt <= slow_in ? 40 : 2;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 0) begin
        wait_cnt <= -1;
        hold <= 4;
      end
      if (hold > 0) hold <= hold - 1;
      // Pulse long enough to survive the host's two-stage sync
      done_out <= (hold > 0) && !fail_en_in;
      fail_out <= (hold > 0) && fail_en_in;
    end
  end
endmodule // esc_dev_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
// ---------------------------------------------------------------
// Bench top: stages structures, hands them over, checks the image
// ---------------------------------------------------------------
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic fail_en = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata, maddr, mwdata;
  logic mwe, req, dn, fl;
  logic [1:0] kind;
  logic [31:0] stg [0:451]; // Staged structure words
  logic [31:0] seed = 32'h0000_0008;
  // Registers read straight after reset, all expected to read zero
  logic [7:0] ra [5] = '{esc_pkg::REG_STATUS, esc_pkg::REG_BASE, esc_pkg::REG_FEAT, 8'h20, esc_pkg::REG_STG_DATA};
  int n_mismatch = 0;
  int comparisons = 0;
  esc_host_ctrl dut (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .MEM_ADDR_OUT(maddr),
    .MEM_WDATA_OUT(mwdata), .MEM_WE_OUT(mwe), .OP_REQ_OUT(req), .OP_KIND_OUT(kind),
    .OP_DONE_IN(dn), .OP_FAIL_IN(fl));
  esc_dev_model mdl (.clk_in(clk), .rst_in(rst), .addr_in(maddr), .wdata_in(mwdata), .we_in(mwe),
    .req_in(req), .fail_en_in(fail_en), .slow_in(slow), .done_out(dn), .fail_out(fl));
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected emitted word for kind k, index i
  function automatic logic [31:0] exp_w(input logic [1:0] k, input int i);
    logic [31:0] w;
    w = stg[i];
    if (k == esc_pkg::KIND_PAGING && i inside {[18:27]}) w = '0;
    if (k == esc_pkg::KIND_TOKEN && i == 0) w = w & 32'h0000_0001;
    if (k == esc_pkg::KIND_TOKEN && i inside {[1:11], [24:31], [40:47], [53:58]}) w = '0;
    if (k == esc_pkg::KIND_SIG && i < 4) w = esc_pkg::SIG_HDR[32*i +: 32];
    if (k == esc_pkg::KIND_SIG && i inside {[6:9]}) w = esc_pkg::SIG_HDR2[32*(i-6) +: 32];
    if (k == esc_pkg::KIND_SIG && i == 128) w = 32'h0000_0003;
    if (k == esc_pkg::KIND_SIG && i inside {[11:31], [227:231], [248:255], [257:259]}) w = '0;
    return w;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stands in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Stage, start, poll, then check status bit eb and the emitted image
  task automatic run(input logic [1:0] k, input logic [31:0] base, input int last, input int eb);
    logic [31:0] st;
    int n0;
    bit em;
    em = (eb == esc_pkg::ST_DONE) || (eb == esc_pkg::ST_FAIL);
    wr(esc_pkg::REG_STG_ADDR, 32'h0000_0000);
    for (int i = 0; i <= last; i++) wr(esc_pkg::REG_STG_DATA, stg[i]);
    wr(esc_pkg::REG_BASE, base);
    n0 = mdl.nwr;
    wr(esc_pkg::REG_CTRL, {29'h0, k, 1'b1});
    for (int j = 0; j < 400; j++) begin
      rd(esc_pkg::REG_STATUS, st);
      if (st[esc_pkg::ST_DONE] === 1'b1) break;
    end
    `CHK(st[esc_pkg::ST_BUSY], 1'b0)
    `CHK(st[eb], 1'b1)
    `CHK(mdl.nwr - n0, em ? last + 1 : 0)
    if (em) for (int i = 0; i <= last; i++) `CHK(mdl.mem[base[11:2] + i], exp_w(k, i))
    // Kind and last address stand until the next hand-over
    if (em) `CHK(kind, k)
    if (em) `CHK(maddr, base + 32'(4 * last))
    rd(esc_pkg::REG_CTRL, st);
    `CHK(st, {29'h0, k, 1'b0})
  endtask
  initial begin
    logic [31:0] d;
    for (int i = 0; i < 452; i++) begin
      seed = lfsr(seed);
      stg[i] = seed;
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      `CHK(d, 32'h0000_0000)
    end
    run(esc_pkg::KIND_PAGING, 32'h0000_3000, 31, esc_pkg::ST_DONE);
    run(esc_pkg::KIND_TOKEN, 32'h0000_1100, 75, esc_pkg::ST_ALIGN);
    fail_en = 1'b1;
    slow = 1'b1;
    run(esc_pkg::KIND_TOKEN, 32'h0000_1200, 75, esc_pkg::ST_FAIL);
    fail_en = 1'b0;
    slow = 1'b0;
    wr(esc_pkg::REG_FEAT, 32'h0000_0001);
    stg[5] = 32'h2015_0930;
    stg[225] = 32'h0000_0003;
    stg[226] = 32'h0000_0007;
    run(esc_pkg::KIND_SIG, 32'h0000_5000, 451, esc_pkg::ST_DONE);
    run(esc_pkg::KIND_SIG, 32'h0000_5010, 451, esc_pkg::ST_ALIGN);
    stg[5] = 32'h2015_1330;
    run(esc_pkg::KIND_SIG, 32'h0000_5000, 451, esc_pkg::ST_DATE);
    stg[5] = 32'h2015_0930;
    stg[225] = 32'h0000_0008;
    run(esc_pkg::KIND_SIG, 32'h0000_5000, 451, esc_pkg::ST_MISC);
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 60000);
    n_mismatch++;
    test_done;
  end
endmodule // tb_top
